// ---- rtl/byte_alu_consts.svh ----
//
// Behaviour
// - Add-with-carry recognised by upper six opcode bits
// - Add sums accumulator, carry, byte; sets flags
// - AND literal into accumulator, result in accumulator
// - AND and complement touch only negative, zero
// - Complement writes inverted byte to destination
// - Quarters: decode, read, process, write
// - Access bit picks access bank or bank_select
// - Extended set: low addresses with access bit clear use indexed offset
// - Compare equal skips next, no store, no flags
// - Increment, store, skip next on zero result
// - Increment, store, skip next on nonzero result
`ifndef BYTE_ALU_CONSTS_SVH
`define BYTE_ALU_CONSTS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL 6'h00
`define OFS_ACC 6'h04
`define OFS_STATUS 6'h08
`define OFS_BANK 6'h0C
`define OFS_INDEX 6'h10
`define OFS_INSTR 6'h14
`define OFS_MADDR 6'h18
`define OFS_MDATA 6'h1C
`define OFS_STATE 6'h20

// ----------------------------------------------------------------
// Opcode patterns and field positions
// ----------------------------------------------------------------
`define OPC_ADDC 6'h08
`define OPC_ANDL 8'h0B
`define OPC_COMPLEMENT_BYTE_OP 6'h07
`define OPC_CPEQ 7'h31
`define OPC_INCZ 6'h0F
`define OPC_INNZ 6'h12
`define BIT_DEST 9
`define BIT_ACC 8
`define BIT_TWO_WORD 16

// ----------------------------------------------------------------
// Addressing constants
// ----------------------------------------------------------------
`define INDEXED_LIMIT 8'h5F
`define ACCESS_LOW_LIMIT 8'h5F
`define BANK_LOW 4'h0
`define BANK_HIGH 4'hF

// ----------------------------------------------------------------
// Quarter and skip counts
// ----------------------------------------------------------------
`define QUARTER_LAST 2'd3
`define SKIP_NOP_ONE 2'd1
`define SKIP_NOP_TWO 2'd2

// ----------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------
`define ST_C 0
`define ST_DC 1
`define ST_Z 2
`define ST_OV 3
`define ST_N 4

`endif

// ---- rtl/byte_alu_pkg.sv ----
package byte_alu_pkg;

	typedef enum logic [1:0] {PH_IDLE, PH_EXEC, PH_NOP} phase_e;

	typedef enum logic [2:0] {
		OP_NONE, OP_ADDC, OP_ANDL, OP_COMPLEMENT_BYTE_OP, OP_CPEQ, OP_INCZ, OP_INNZ
	} op_e;

	typedef struct packed {
		phase_e phase;
		op_e op;
		logic [1:0] q;
		logic [1:0] nop_left;
		logic [15:0] opcode;
		logic [11:0] ea;
		logic [7:0] operand;
		logic [7:0] result;
		logic [7:0] acc;
		logic [4:0] status;
		logic [3:0] bank;
		logic [11:0] index_base;
		logic ext_en;
		logic skip_pend;
		logic [11:0] mem_addr;
		logic [15:0] cycles;
		logic waitreq;
		logic [31:0] readdata;
	} core_s;

endpackage

// ---- rtl/byte_alu_skip_instructions.sv ----
`timescale 1ns/1ps
`include "byte_alu_consts.svh"

module byte_alu_skip_instructions
	import byte_alu_pkg::*;
#(
	parameter int DMEM_AW = 12
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// Avalon-MM slave
	input wire logic [5:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [31:0] o_readdata,
	output logic o_waitrequest
);

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------

	// Byte-lane merge of new write data over current contents
	function automatic logic [31:0] merge_lanes(
		input logic [31:0] cur,
		input logic [31:0] wd,
		input logic [3:0] be
	);
		logic [31:0] r;
		r = cur;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Opcode classification
	function automatic op_e decode_op(input logic [15:0] opc);
		op_e r;
		r = OP_NONE;
		if (opc[15:10] == `OPC_ADDC) begin
			r = OP_ADDC;
		end else if (opc[15:8] == `OPC_ANDL) begin
			r = OP_ANDL;
		end else if (opc[15:10] == `OPC_COMPLEMENT_BYTE_OP) begin
			r = OP_COMPLEMENT_BYTE_OP;
		end else if (opc[15:9] == `OPC_CPEQ) begin
			r = OP_CPEQ;
		end else if (opc[15:10] == `OPC_INCZ) begin
			r = OP_INCZ;
		end else if (opc[15:10] == `OPC_INNZ) begin
			r = OP_INNZ;
		end
		return r;
	endfunction

	// Effective data address from file address and access bit
	function automatic logic [11:0] eff_addr(
		input logic [7:0] f,
		input logic a,
		input logic [3:0] bank,
		input logic ext,
		input logic [11:0] base
	);
		logic [11:0] r;
		r = {bank, f};
		if (!a && ext && (f <= `INDEXED_LIMIT)) begin
			r = 12'(base + {4'h0, f});
		end else if (!a) begin
			if (f <= `ACCESS_LOW_LIMIT) begin
				r = {`BANK_LOW, f};
			end else begin
				r = {`BANK_HIGH, f};
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// State and data memory
	// ------------------------------------------------------------
	core_s st;
	core_s nx;
	logic [7:0] dmem [0:(1 << DMEM_AW) - 1];
	logic mem_we;
	logic [11:0] mem_wa;
	logic [7:0] mem_wd;
	logic [7:0] rd_op;
	logic [7:0] rd_bus;
	logic [31:0] rd_reg;
	logic [31:0] wv;
	logic [5:0] ofs;
	logic req;
	logic [8:0] sum9;
	logic [4:0] sum_lo;
	logic [7:0] inc_val;

	// Asynchronous read ports; narrow address keeps index in range
	assign rd_op = dmem[st.ea[DMEM_AW-1:0]];
	assign rd_bus = dmem[st.mem_addr[DMEM_AW-1:0]];
	assign ofs = {i_address[5:2], 2'b00};

	// Register readback for the addressed word
	always_comb begin
		rd_reg = 32'h0000_0000;
		if (ofs == `OFS_CTRL) begin
			rd_reg = {31'h0, st.ext_en};
		end else if (ofs == `OFS_ACC) begin
			rd_reg = {24'h0, st.acc};
		end else if (ofs == `OFS_STATUS) begin
			rd_reg = {27'h0, st.status};
		end else if (ofs == `OFS_BANK) begin
			rd_reg = {28'h0, st.bank};
		end else if (ofs == `OFS_INDEX) begin
			rd_reg = {20'h0, st.index_base};
		end else if (ofs == `OFS_INSTR) begin
			rd_reg = {16'h0, st.opcode};
		end else if (ofs == `OFS_MADDR) begin
			rd_reg = {20'h0, st.mem_addr};
		end else if (ofs == `OFS_MDATA) begin
			rd_reg = {24'h0, rd_bus};
		end else if (ofs == `OFS_STATE) begin
			rd_reg = {st.cycles, st.result, 6'h0, st.skip_pend,
				(st.phase != PH_IDLE)};
		end
	end

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------

	// Bus access and instruction sequencing in one place
	always_comb begin
		nx = st;
		mem_we = 1'b0;
		mem_wa = st.mem_addr;
		mem_wd = 8'h00;
		wv = merge_lanes(rd_reg, i_writedata, i_byteenable);
		// Operands widened first so the carry out is never lost
		sum9 = {1'b0, st.acc} + {1'b0, st.operand}
			+ {8'h00, st.status[`ST_C]};
		sum_lo = {1'b0, st.acc[3:0]} + {1'b0, st.operand[3:0]}
			+ {4'h0, st.status[`ST_C]};
		inc_val = 8'(st.operand + 8'h01);
		nx.waitreq = 1'b1;
		// Stall every access while executing, so no bus write races Q4
		req = (i_read || i_write) && st.waitreq && (st.phase == PH_IDLE);
		if (req) begin
			nx.waitreq = 1'b0;
			nx.readdata = rd_reg;
			if (i_write) begin
				if (ofs == `OFS_CTRL) begin
					nx.ext_en = wv[0];
				end else if (ofs == `OFS_ACC) begin
					nx.acc = wv[7:0];
				end else if (ofs == `OFS_STATUS) begin
					nx.status = wv[4:0];
				end else if (ofs == `OFS_BANK) begin
					nx.bank = wv[3:0];
				end else if (ofs == `OFS_INDEX) begin
					nx.index_base = wv[11:0];
				end else if (ofs == `OFS_INSTR) begin
					nx.q = 2'd0;
					if (st.skip_pend) begin
						nx.phase = PH_NOP;
						nx.skip_pend = 1'b0;
						nx.nop_left = wv[`BIT_TWO_WORD] ? `SKIP_NOP_TWO
							: `SKIP_NOP_ONE;
					end else begin
						nx.phase = PH_EXEC;
						nx.opcode = wv[15:0];
					end
				end else if (ofs == `OFS_MADDR) begin
					nx.mem_addr = wv[11:0];
				end else if (ofs == `OFS_MDATA) begin
					mem_we = 1'b1;
					mem_wd = wv[7:0];
				end
			end
		end
		case (st.phase)
			PH_IDLE: begin
				nx.q = 2'd0;
			end
			PH_EXEC: begin
				nx.q = 2'(st.q + 2'd1);
				case (st.q)
					2'd0: begin
						// Decode quarter
						nx.op = decode_op(st.opcode);
						nx.ea = eff_addr(st.opcode[7:0],
							st.opcode[`BIT_ACC], st.bank, st.ext_en,
							st.index_base);
					end
					2'd1: begin
						// Read quarter; literal replaces the data byte
						nx.operand = (st.op == OP_ANDL) ? st.opcode[7:0]
							: rd_op;
					end
					2'd2: begin
						// Process quarter
						case (st.op)
							OP_ADDC: begin
								nx.result = sum9[7:0];
								nx.status[`ST_C] = sum9[8];
								nx.status[`ST_DC] = sum_lo[4];
								nx.status[`ST_Z] = (sum9[7:0] == 8'h00);
								nx.status[`ST_N] = sum9[7];
								nx.status[`ST_OV] =
									(st.acc[7] == st.operand[7])
									&& (sum9[7] != st.acc[7]);
							end
							OP_ANDL: begin
								nx.result = st.acc & st.operand;
								nx.status[`ST_Z] =
									((st.acc & st.operand) == 8'h00);
								nx.status[`ST_N] = st.acc[7] & st.operand[7];
							end
							OP_COMPLEMENT_BYTE_OP: begin
								nx.result = ~st.operand;
								nx.status[`ST_Z] = (st.operand == 8'hFF);
								nx.status[`ST_N] = ~st.operand[7];
							end
							OP_CPEQ: begin
								nx.result = 8'(st.operand - st.acc);
								nx.skip_pend = (st.operand == st.acc);
							end
							OP_INCZ: begin
								nx.result = inc_val;
								nx.skip_pend = (inc_val == 8'h00);
							end
							OP_INNZ: begin
								nx.result = inc_val;
								nx.skip_pend = (inc_val != 8'h00);
							end
							default: begin
								nx.result = st.result;
							end
						endcase
					end
					default: begin
						// Write quarter
						nx.phase = PH_IDLE;
						nx.cycles = 16'(st.cycles + 16'h0001);
						if (st.op == OP_ANDL) begin
							nx.acc = st.result;
						end else if ((st.op != OP_NONE)
							&& (st.op != OP_CPEQ)) begin
							if (st.opcode[`BIT_DEST]) begin
								mem_we = 1'b1;
								mem_wa = st.ea;
								mem_wd = st.result;
							end else begin
								nx.acc = st.result;
							end
						end
					end
				endcase
			end
			PH_NOP: begin
				nx.q = 2'(st.q + 2'd1);
				if (st.q == `QUARTER_LAST) begin
					nx.cycles = 16'(st.cycles + 16'h0001);
					if (st.nop_left == `SKIP_NOP_ONE) begin
						nx.phase = PH_IDLE;
					end
					nx.nop_left = 2'(st.nop_left - 2'd1);
				end
			end
			default: begin
				nx.phase = PH_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// State registers
	// ------------------------------------------------------------

	// Whole state in one register; waitrequest idles high
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			st <= '0;
			st.waitreq <= 1'b1;
		end else begin
			st <= nx;
		end
	end

	// Data memory write port, contents not reset
	always_ff @(posedge i_clk_sys) begin
		if (mem_we) begin
			dmem[mem_wa[DMEM_AW-1:0]] <= mem_wd;
		end
	end

	assign o_readdata = st.readdata;
	assign o_waitrequest = st.waitreq;

endmodule

// ---- sim/byte_alu_skip_instructions_chk.sv ----
`timescale 1ns/1ps
`include "byte_alu_consts.svh"

module byte_alu_skip_instructions_chk
	import byte_alu_pkg::*;
#(
	parameter int DMEM_AW = 12
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// Bus signals
	input wire logic [5:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	input wire logic [31:0] o_readdata,
	input wire logic o_waitrequest
);
	// ----------------------------------------------------------------
	// Bus and timing checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	logic rd_ok;

	// Completed read, so readdata is meaningful
	assign rd_ok = i_read && !o_waitrequest;

	a_reset_idle: assert property ($fell(i_rst) |-> o_waitrequest
		&& o_readdata == 32'h0) else $error("Bus not idle after reset");
	a_ack_single: assert property (!o_waitrequest |=> o_waitrequest)
		else $error("Acknowledge held too long");
	a_ack_caused: assert property (!o_waitrequest |-> $past(i_read || i_write))
		else $error("Acknowledge without request");
	a_exec_quarters: assert property (!o_waitrequest && i_write &&
		i_address == `OFS_INSTR |=> o_waitrequest [*4])
		else $error("Access taken during execution");
	a_idle_on_read: assert property (rd_ok &&
		i_address == `OFS_STATE |-> !o_readdata[0])
		else $error("Busy seen on accepted read");
	a_acc_byte: assert property (rd_ok &&
		i_address == `OFS_ACC |-> o_readdata[31:8] == 24'h0)
		else $error("Accumulator wider than a byte");
	a_status_bits: assert property (rd_ok &&
		i_address == `OFS_STATUS |-> o_readdata[31:5] == 27'h0)
		else $error("Status has extra bits");
	a_bank_bits: assert property (rd_ok &&
		i_address == `OFS_BANK |-> o_readdata[31:4] == 28'h0)
		else $error("Bank select has extra bits");
	a_unmapped_zero: assert property (rd_ok &&
		{i_address[5:2], 2'h0} > `OFS_STATE |-> o_readdata == 32'h0)
		else $error("Unmapped read not zero");
endmodule

// ---- sim/byte_alu_skip_instructions_bench.sv ----
`timescale 1ns/1ps
`include "byte_alu_consts.svh"

module byte_alu_skip_instructions_bench;
	import byte_alu_pkg::*;
	logic i_clk_sys, i_rst, i_read, i_write;
	logic [5:0] i_address;
	logic [31:0] i_writedata, o_readdata, q, lfsr, r, r2;
	logic [3:0] i_byteenable, bank;
	logic o_waitrequest, d, a, ext, two, e_skip;
	logic [7:0] f, lit, e_acc, e_mem;
	logic [4:0] e_st;
	logic [11:0] base, ea;
	logic [15:0] op, cyc;
	int fail_count, comparisons, k;

	byte_alu_skip_instructions dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
		.i_address(i_address), .i_read(i_read), .i_write(i_write),
		.i_writedata(i_writedata), .i_byteenable(i_byteenable),
		.o_readdata(o_readdata), .o_waitrequest(o_waitrequest));

	// 250 MHz clock
	initial begin
		i_clk_sys = 1'b0;
		forever #2 i_clk_sys = ~i_clk_sys;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task summarize;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Hold request until waitrequest sampled low; bounded wait
	task automatic bus(input logic w, input logic [5:0] ad,
		input logic [31:0] wd);
		int n = 0;
		@(posedge i_clk_sys);
		i_write <= w;
		i_read <= !w;
		i_address <= ad;
		i_writedata <= wd;
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (o_waitrequest !== 1'b0 && n < 40);
		if (n >= 40) begin
			fail_count++;
			summarize();
		end
		q = o_readdata;
		i_read <= 1'b0;
		i_write <= 1'b0;
	endtask

	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction

	// Expected effective address of a file operand
	function automatic logic [11:0] eaddr();
		if (a) return {bank, f};
		if (f <= 8'h5F) return ext ? base + {4'h0, f} : {4'h0, f};
		return {4'hF, f};
	endfunction

	// Expected accumulator, memory, flags and skip of one instruction
	task automatic model();
		logic [8:0] s;
		logic [7:0] res;
		res = e_mem;
		e_skip = 1'b0;
		case (k)
			0: begin
				s = e_acc + e_mem + e_st[0];
				res = s[7:0];
				e_st[1] = ({1'b0, e_acc[3:0]} + e_mem[3:0] + e_st[0]) > 5'hF;
				e_st[3] = e_acc[7] == e_mem[7] && res[7] != e_acc[7];
				e_st[0] = s[8];
			end
			1: res = e_acc & lit;
			2: res = ~e_mem;
			3: e_skip = e_mem == e_acc;
			4: begin
				res = e_mem + 8'h1;
				e_skip = res == 8'h0;
			end
			default: begin
				res = e_mem + 8'h1;
				e_skip = res != 8'h0;
			end
		endcase
		if (k < 3) begin
			e_st[2] = res == 8'h0;
			e_st[4] = res[7];
		end
		if (k == 1 || (k != 3 && !d)) e_acc = res;
		else if (k != 3) e_mem = res;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{i_rst, i_read, i_write, i_address, i_writedata} = {1'b1, 40'h0};
		i_byteenable = 4'hF;
		lfsr = 32'hECFE76F8;
		fail_count = 0;
		comparisons = 0;
		repeat (4) @(posedge i_clk_sys);
		i_rst <= 1'b0;
		// Reset values, memory word excluded
		for (int i = 0; i < 9; i++) if (i != 7) begin
			bus(1'b0, 6'(i * 4), 32'h0);
			chk(q, 32'h0);
		end
		bus(1'b1, 6'h3C, 32'hFFFFFFFF);
		bus(1'b0, 6'h3C, 32'h0);
		chk(q, 32'h0);
		// Unknown opcode: one cycle spent, nothing else changes
		bus(1'b1, `OFS_INSTR, 32'h0000FFFF);
		bus(1'b0, `OFS_ACC, 32'h0);
		chk(q, 32'h0);
		bus(1'b0, `OFS_STATE, 32'h0);
		chk(q, 32'h0001_0000);
		for (int it = 0; it < 80; it++) begin
			r = rnd();
			r2 = rnd();
			k = int'(r[2:0]) % 6;
			{two, ext, a, d} = r[6:3];
			f = r[7] ? (r[8] ? 8'h5F : 8'h60) : r[15:8];
			lit = r[23:16];
			bank = r[27:24];
			base = r2[27:16];
			e_acc = r2[15:8];
			e_st = r2[4:0];
			e_mem = r2[31] ? (k == 3 ? e_acc : 8'hFF) : r2[7:0];
			case (k)
				0: op = {`OPC_ADDC, d, a, f};
				1: op = {`OPC_ANDL, lit};
				2: op = {`OPC_COMPLEMENT_BYTE_OP, d, a, f};
				3: op = {`OPC_CPEQ, a, f};
				4: op = {`OPC_INCZ, d, a, f};
				default: op = {`OPC_INNZ, d, a, f};
			endcase
			ea = eaddr();
			bus(1'b1, `OFS_CTRL, {31'h0, ext});
			bus(1'b1, `OFS_ACC, {24'h0, e_acc});
			bus(1'b1, `OFS_STATUS, {27'h0, e_st});
			bus(1'b1, `OFS_BANK, {28'h0, bank});
			bus(1'b1, `OFS_INDEX, {20'h0, base});
			bus(1'b1, `OFS_MADDR, {20'h0, ea});
			bus(1'b1, `OFS_MDATA, {24'h0, e_mem});
			model();
			bus(1'b1, `OFS_INSTR, {16'h0, op});
			bus(1'b0, `OFS_ACC, 32'h0);
			chk(q, {24'h0, e_acc});
			bus(1'b0, `OFS_STATUS, 32'h0);
			chk(q, {27'h0, e_st});
			bus(1'b0, `OFS_MDATA, 32'h0);
			chk(q, {24'h0, e_mem});
			bus(1'b0, `OFS_STATE, 32'h0);
			chk({31'h0, q[1]}, {31'h0, e_skip});
			cyc = q[31:16];
			if (e_skip) begin
				bus(1'b1, `OFS_INSTR, {15'h0, two, `OPC_ANDL, 8'h00});
				bus(1'b0, `OFS_ACC, 32'h0);
				chk(q, {24'h0, e_acc});
				bus(1'b0, `OFS_STATE, 32'h0);
				cyc = cyc + (two ? 16'h2 : 16'h1);
				chk({q[31:16], 15'h0, q[1]}, {cyc, 16'h0});
				bus(1'b0, `OFS_INSTR, 32'h0);
				chk({16'h0, q[15:0]}, {16'h0, op});
			end
		end
		summarize();
	end
endmodule

bind byte_alu_skip_instructions byte_alu_skip_instructions_chk
	#(.DMEM_AW(DMEM_AW)) chk_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
	.i_address(i_address), .i_read(i_read), .i_write(i_write),
	.i_writedata(i_writedata), .i_byteenable(i_byteenable),
	.o_readdata(o_readdata), .o_waitrequest(o_waitrequest));
